// File: rtl/sdtg_defines.vh
`ifndef SDTG_DEFINES_VH
`define SDTG_DEFINES_VH

// Line type codes
`define SDTG_LT_DOUBLE_EQUALIZE   4'h0
`define SDTG_LT_DOUBLE_BROAD      4'h1
`define SDTG_LT_EQUALIZE_BROAD    4'h2
`define SDTG_LT_BROAD_EQUALIZE    4'h3
`define SDTG_LT_FULL_EQUALIZE     4'h4
`define SDTG_LT_FULL_BROAD        4'h5
`define SDTG_LT_FULL_NORMAL_SYNC  4'h6
`define SDTG_LT_SYNC_PICTURE      4'h7
`define SDTG_LT_PICTURE_EQUALIZE  4'h8
`define SDTG_LT_PICTURE           4'h9

// 525-line interlaced preset: breakpoints, frame and field size
`define SDTG_BP_0        10'h004
`define SDTG_BP_1        10'h007
`define SDTG_BP_2        10'h00a
`define SDTG_BP_3        10'h014
`define SDTG_BP_4        10'h107
`define SDTG_BP_5        10'h108
`define SDTG_BP_6        10'h10a
`define SDTG_BP_7        10'h10b
`define SDTG_BP_8        10'h10d
`define SDTG_BP_9        10'h10e
`define SDTG_BP_10       10'h110
`define SDTG_BP_11       10'h111
`define SDTG_BP_12       10'h11a
`define SDTG_BP_13       10'h11b
`define SDTG_BP_14       10'h20e
`define SDTG_FRAME_SIZE  10'h20d
`define SDTG_FIELD_SIZE  10'h107

// Fixed state durations in pixel clocks (T = one pixel clock)
`define SDTG_T1          14'sh0001
`define SDTG_T2          14'sh0002

// Timing modes
`define SDTG_MODE_SD     1'b0
`define SDTG_MODE_MON    1'b1

// Sync insertion modes
`define SDTG_SYNC_NONE   2'h0
`define SDTG_SYNC_GREEN  2'h1
`define SDTG_SYNC_ALL    2'h2

// Output level selectors
`define SDTG_SEL_BLANK   2'h0
`define SDTG_SEL_LOW     2'h1
`define SDTG_SEL_HIGH    2'h2
`define SDTG_SEL_VIDEO   2'h3

// Code ranges and converter offset
`define SDTG_CODE_LO     10'h040
`define SDTG_LUMA_HI     10'h3ac
`define SDTG_CHROMA_HI   10'h3c0
`define SDTG_DC_OFFSET   11'h200
`define SDTG_CODE_MAX    11'h7ff

`endif

// File: rtl/sdtg_core.v
// Functional notes
// - Broad-then-equalize line: 1T,h,2T,g-h-4,1T,1T,c,2T,g-c-4,1T.
// - Sync-then-picture line: 1T,a,2T,g-a+d1-3,g-d1-k,k1,1T.
// - Lines with picture forward input video during state five, always.
// - Picture-then-equalize line: 1T,a,2T,d-a-3,g-d-k1,k-1,1T,1T,c,2T,g-c-4,1T.
// - Full picture line: 1T,a,2T,d-a-3,total-d-k,k-1,1T.
// - Preset field one switches types at lines 4,7,10,20,263.
// - Preset field two switches at 264..283 and 526 as tabled.
// - Preset frame size 525 lines, field size 263 lines.
// - First field 263 lines, second field 262 lines.
// - Generated levels on non-video types; forwarding still passes picture spans.
// - Monitor mode always drives converters from the input bus.
// - Override levels come from programmable blank, sync-low, sync-high codes.
// - Full-scale select picks one of two converter ranges.
// - RGB offset select adds the offset on all three channels.
// - Colour-difference mode offsets luma only; chroma is offset binary.
// - Luma and RGB codes span 64 to 940, colour-difference chroma 64 to 960; 64 is blank, 940 luma peak.
// - Out-of-range codes are clipped or passed per stage setting.
// - Sync on green: sync on channel zero only, others stay blank.
// - Sync on all: programmed levels on all channels, no-sync ones blank.
// - No-sync mode: no sync on converters, separate line/frame syncs.
// - Each converter datapath is 11 bits wide.
// - Clip/shift/scale stage can be bypassed entirely.
// - Each type lasts from its breakpoint until the next breakpoint.
// - Full normal sync line forwards video in states 4 and 5 if enabled.
`include "sdtg_defines.vh"

module sdtg_core (
   input  wire        core_clk_in,
   input  wire        rst_in,
   input  wire        clk_en_in,
   input  wire        timing_mode_in,
   input  wire [1:0]  sync_mode_in,
   input  wire        video_forward_enable_in,
   input  wire        rgb_offset_select_in,
   input  wire        clip_enable_in,
   input  wire        stage_bypass_in,
   input  wire        fullscale_select_in,
   input  wire [10:0] normal_sync_width_in,
   input  wire [10:0] equalize_pulse_width_in,
   input  wire [10:0] broad_pulse_width_in,
   input  wire [10:0] half_line_length_in,
   input  wire [10:0] picture_start_offset_in,
   input  wire [10:0] second_half_picture_start_in,
   input  wire [10:0] picture_end_offset_in,
   input  wire [10:0] first_half_picture_end_in,
   input  wire [11:0] pixels_per_line_in,
   input  wire [9:0]  luma_blank_level_code_in,
   input  wire [9:0]  luma_sync_low_level_code_in,
   input  wire [9:0]  luma_sync_high_level_code_in,
   input  wire [9:0]  chroma_blank_level_code_in,
   input  wire [9:0]  chroma_sync_low_level_code_in,
   input  wire [9:0]  chroma_sync_high_level_code_in,
   input  wire [9:0]  video_g_y_in,
   input  wire [9:0]  video_b_pb_in,
   input  wire [9:0]  video_r_pr_in,
   output wire [10:0] dac_g_y_out,
   output wire [10:0] dac_b_pb_out,
   output wire [10:0] dac_r_pr_out,
   output reg         dac_fullscale_out,
   output reg         line_sync_out,
   output reg         frame_sync_out,
   output reg         field_out,
   output reg  [9:0]  line_count_out
);

   reg  [3:0]  state_r, state_nxt;
   reg  [11:0] cnt_r, cnt_nxt;
   reg  [9:0]  line_r, line_nxt;
   reg  [3:0]  ltype_r, ltype_nxt;
   wire [3:0]  last_state;
   wire [1:0]  sel;
   wire [29:0] video_all;
   wire [32:0] dac_all;

   // Preset line type table: a type runs up to the line before its
   // breakpoint, the next entry taking over at that line
   function [3:0] type_of_line;
      input [9:0] ln;
      begin
         if (ln < `SDTG_BP_0)
            type_of_line = `SDTG_LT_DOUBLE_EQUALIZE;
         else if (ln < `SDTG_BP_1)
            type_of_line = `SDTG_LT_DOUBLE_BROAD;
         else if (ln < `SDTG_BP_2)
            type_of_line = `SDTG_LT_DOUBLE_EQUALIZE;
         else if (ln < `SDTG_BP_3)
            type_of_line = `SDTG_LT_FULL_NORMAL_SYNC;
         else if (ln < `SDTG_BP_4)
            type_of_line = `SDTG_LT_PICTURE;
         else if (ln < `SDTG_BP_5)
            type_of_line = `SDTG_LT_PICTURE_EQUALIZE;
         else if (ln < `SDTG_BP_6)
            type_of_line = `SDTG_LT_DOUBLE_EQUALIZE;
         else if (ln < `SDTG_BP_7)
            type_of_line = `SDTG_LT_EQUALIZE_BROAD;
         else if (ln < `SDTG_BP_8)
            type_of_line = `SDTG_LT_DOUBLE_BROAD;
         else if (ln < `SDTG_BP_9)
            type_of_line = `SDTG_LT_BROAD_EQUALIZE;
         else if (ln < `SDTG_BP_10)
            type_of_line = `SDTG_LT_DOUBLE_EQUALIZE;
         else if (ln < `SDTG_BP_11)
            type_of_line = `SDTG_LT_FULL_EQUALIZE;
         else if (ln < `SDTG_BP_12)
            type_of_line = `SDTG_LT_FULL_NORMAL_SYNC;
         else if (ln < `SDTG_BP_13)
            type_of_line = `SDTG_LT_SYNC_PICTURE;
         else
            type_of_line = `SDTG_LT_PICTURE;
      end
   endfunction

   function [3:0] final_state;
      input [3:0] t;
      begin
         case (t)
            `SDTG_LT_DOUBLE_EQUALIZE,
            `SDTG_LT_DOUBLE_BROAD,
            `SDTG_LT_EQUALIZE_BROAD,
            `SDTG_LT_BROAD_EQUALIZE:   final_state = 4'ha;
            `SDTG_LT_FULL_EQUALIZE,
            `SDTG_LT_FULL_BROAD:       final_state = 4'h5;
            `SDTG_LT_FULL_NORMAL_SYNC: final_state = 4'h6;
            `SDTG_LT_PICTURE_EQUALIZE: final_state = 4'hc;
            default:                   final_state = 4'h7;
         endcase
      end
   endfunction

   // Duration of state s of type t in pixel clocks, at least one
   function [11:0] duration;
      input [3:0] t;
      input [3:0] s;
      reg signed [13:0] a, c, h, g, d, d1, k, k1, tot, w1, w2, r;
      begin
         a   = {3'h0, normal_sync_width_in};
         c   = {3'h0, equalize_pulse_width_in};
         h   = {3'h0, broad_pulse_width_in};
         g   = {3'h0, half_line_length_in};
         d   = {3'h0, picture_start_offset_in};
         d1  = {3'h0, second_half_picture_start_in};
         k   = {3'h0, picture_end_offset_in};
         k1  = {3'h0, first_half_picture_end_in};
         tot = {2'h0, pixels_per_line_in};
         w1  = (t == `SDTG_LT_DOUBLE_BROAD ||
                t == `SDTG_LT_BROAD_EQUALIZE ||
                t == `SDTG_LT_FULL_BROAD) ? h : c;
         w2  = (t == `SDTG_LT_DOUBLE_BROAD ||
                t == `SDTG_LT_EQUALIZE_BROAD) ? h : c;
         r   = `SDTG_T1;
         case (t)
            `SDTG_LT_DOUBLE_EQUALIZE,
            `SDTG_LT_DOUBLE_BROAD,
            `SDTG_LT_EQUALIZE_BROAD,
            `SDTG_LT_BROAD_EQUALIZE:
               case (s)
                  4'h2:    r = w1;
                  4'h3:    r = `SDTG_T2;
                  4'h4:    r = g - w1 - 14'sd4;
                  4'h7:    r = w2;
                  4'h8:    r = `SDTG_T2;
                  4'h9:    r = g - w2 - 14'sd4;
                  default: r = `SDTG_T1;
               endcase
            `SDTG_LT_FULL_EQUALIZE,
            `SDTG_LT_FULL_BROAD:
               case (s)
                  4'h2:    r = w1;
                  4'h3:    r = `SDTG_T2;
                  4'h4:    r = tot - w1 - 14'sd4;
                  default: r = `SDTG_T1;
               endcase
            `SDTG_LT_FULL_NORMAL_SYNC:
               case (s)
                  4'h2:    r = a;
                  4'h3:    r = `SDTG_T2;
                  4'h4:    r = g - a - 14'sd4;
                  4'h5:    r = g;
                  default: r = `SDTG_T1;
               endcase
            `SDTG_LT_SYNC_PICTURE:
               case (s)
                  4'h2:    r = a;
                  4'h3:    r = `SDTG_T2;
                  4'h4:    r = g - a + d1 - 14'sd3;
                  4'h5:    r = g - d1 - k;
                  4'h6:    r = k1;
                  default: r = `SDTG_T1;
               endcase
            `SDTG_LT_PICTURE_EQUALIZE:
               case (s)
                  4'h2:    r = a;
                  4'h3:    r = `SDTG_T2;
                  4'h4:    r = d - a - 14'sd3;
                  4'h5:    r = g - d - k1;
                  4'h6:    r = k - 14'sd1;
                  4'h9:    r = c;
                  4'ha:    r = `SDTG_T2;
                  4'hb:    r = g - c - 14'sd4;
                  default: r = `SDTG_T1;
               endcase
            default:
               case (s)
                  4'h2:    r = a;
                  4'h3:    r = `SDTG_T2;
                  4'h4:    r = d - a - 14'sd3;
                  4'h5:    r = tot - d - k;
                  4'h6:    r = k - 14'sd1;
                  default: r = `SDTG_T1;
               endcase
         endcase
         if (r < `SDTG_T1)
            r = `SDTG_T1;
         duration = r[11:0];
      end
   endfunction

   // Which level a state shows: sync tip, rising step, video or blank
   function [1:0] level_of;
      input [3:0] t;
      input [3:0] s;
      input       fwd;
      begin
         level_of = `SDTG_SEL_BLANK;
         case (t)
            `SDTG_LT_DOUBLE_EQUALIZE,
            `SDTG_LT_DOUBLE_BROAD,
            `SDTG_LT_EQUALIZE_BROAD,
            `SDTG_LT_BROAD_EQUALIZE:
               if (s == 4'h2 || s == 4'h7)
                  level_of = `SDTG_SEL_LOW;
               else if (s == 4'h3 || s == 4'h8)
                  level_of = `SDTG_SEL_HIGH;
            `SDTG_LT_FULL_NORMAL_SYNC:
               if (s == 4'h2)
                  level_of = `SDTG_SEL_LOW;
               else if (s == 4'h3)
                  level_of = `SDTG_SEL_HIGH;
               else if (fwd && (s == 4'h4 || s == 4'h5))
                  level_of = `SDTG_SEL_VIDEO;
            `SDTG_LT_SYNC_PICTURE,
            `SDTG_LT_PICTURE_EQUALIZE,
            `SDTG_LT_PICTURE:
               if (s == 4'h2 || s == 4'h9)
                  level_of = `SDTG_SEL_LOW;
               else if (s == 4'h3 || s == 4'ha)
                  level_of = `SDTG_SEL_HIGH;
               else if (s == 4'h5)
                  level_of = `SDTG_SEL_VIDEO;
            default:
               if (s == 4'h2)
                  level_of = `SDTG_SEL_LOW;
               else if (s == 4'h3)
                  level_of = `SDTG_SEL_HIGH;
         endcase
      end
   endfunction

   assign last_state = final_state(ltype_r);
   assign sel        = level_of(ltype_r, state_r, video_forward_enable_in);
   assign video_all  = {video_r_pr_in, video_b_pb_in, video_g_y_in};

   // State sequencer with per-state down-counter
   always @* begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r - 12'h001;
      line_nxt  = line_r;
      ltype_nxt = ltype_r;
      if (cnt_r == 12'h000) begin
         if (state_r >= last_state) begin
            state_nxt = 4'h1;
            if (line_r >= `SDTG_FRAME_SIZE)
               line_nxt = 10'h001;
            else
               line_nxt = line_r + 10'h001;
            ltype_nxt = type_of_line(line_nxt);
         end else begin
            state_nxt = state_r + 4'h1;
         end
         cnt_nxt = duration(ltype_nxt, state_nxt) - 12'h001;
      end
   end

   always @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r           <= 4'h1;
         cnt_r             <= 12'h000;
         line_r            <= 10'h001;
         ltype_r           <= `SDTG_LT_DOUBLE_EQUALIZE;
         dac_fullscale_out <= 1'b0;
         line_sync_out     <= 1'b0;
         frame_sync_out    <= 1'b0;
         field_out         <= 1'b0;
         line_count_out    <= 10'h001;
      end else if (clk_en_in) begin
         state_r           <= state_nxt;
         cnt_r             <= cnt_nxt;
         line_r            <= line_nxt;
         ltype_r           <= ltype_nxt;
         dac_fullscale_out <= fullscale_select_in;
         // Separate syncs, valid in every sync mode
         line_sync_out     <= (state_r == 4'h2);
         frame_sync_out    <= (ltype_r == `SDTG_LT_DOUBLE_BROAD ||
                               ltype_r == `SDTG_LT_EQUALIZE_BROAD ||
                               ltype_r == `SDTG_LT_BROAD_EQUALIZE);
         field_out         <= (line_r > `SDTG_FIELD_SIZE);
         line_count_out    <= line_r;
      end
   end

   // Per-channel datapath: channel 0 is green/luma, 1 and 2 chroma or R/B
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
         reg  [10:0] dac_r, dac_nxt;
         reg  [9:0]  vid, hi, lvl;
         reg  [10:0] code;
         reg  [11:0] sum;
         reg         sync_here, add_ofs;
         always @* begin
            vid  = video_all[ch*10 +: 10];
            hi   = (ch == 0 || rgb_offset_select_in) ?
                   `SDTG_LUMA_HI : `SDTG_CHROMA_HI;
            // Clip/shift/scale stage
            if (stage_bypass_in)
               code = {1'b0, vid};
            else if (clip_enable_in && vid < `SDTG_CODE_LO)
               code = {1'b0, `SDTG_CODE_LO};
            else if (clip_enable_in && vid > hi)
               code = {1'b0, hi};
            else
               code = {1'b0, vid};
            sync_here = (sync_mode_in == `SDTG_SYNC_ALL) ||
                        (sync_mode_in == `SDTG_SYNC_GREEN &&
                         ch == 0);
            if (sync_mode_in == `SDTG_SYNC_NONE)
               sync_here = 1'b0;
            lvl = (ch == 0) ? luma_blank_level_code_in
                            : chroma_blank_level_code_in;
            if (sync_here && sel == `SDTG_SEL_LOW)
               lvl = (ch == 0) ? luma_sync_low_level_code_in
                               : chroma_sync_low_level_code_in;
            else if (sync_here && sel == `SDTG_SEL_HIGH)
               lvl = (ch == 0) ? luma_sync_high_level_code_in
                               : chroma_sync_high_level_code_in;
            if (timing_mode_in == `SDTG_MODE_SD &&
                sel != `SDTG_SEL_VIDEO)
               code = {1'b0, lvl};
            // Offset on all channels in RGB, on luma only otherwise
            add_ofs = rgb_offset_select_in || ch == 0;
            sum     = {1'b0, code} +
                      (add_ofs ? {1'b0, `SDTG_DC_OFFSET} : 12'h000);
            dac_nxt = sum[11] ? `SDTG_CODE_MAX : sum[10:0];
         end
         always @(posedge core_clk_in or posedge rst_in) begin
            if (rst_in)
               dac_r <= 11'h000;
            else if (clk_en_in)
               dac_r <= dac_nxt;
         end
         assign dac_all[ch*11 +: 11] = dac_r;
      end
   endgenerate
   assign dac_g_y_out  = dac_all[10:0];
   assign dac_b_pb_out = dac_all[21:11];
   assign dac_r_pr_out = dac_all[32:22];
endmodule // sdtg_core

// File: dv/sdtg_video_src.sv
module sdtg_video_src (
   input  logic       core_clk_in,
   input  logic       wide_in,
   output logic [9:0] g_y_out,
   output logic [9:0] b_pb_out,
   output logic [9:0] r_pr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      g_y_out = 10'h100;
      b_pb_out = 10'h100;
      r_pr_out = 10'h100;
   end
   // Fresh codes every pixel; the full code range only when asked, so the
   // clip stage is reached without overdriving the converters
   function automatic logic [9:0] pick();
      return wide_in ? 10'($urandom) : 10'h100 + 10'($urandom % 685);
   endfunction
   always @(negedge core_clk_in) begin
      g_y_out <= pick();
      b_pb_out <= pick();
      r_pr_out <= pick();
   end
endmodule // sdtg_video_src

// File: dv/sdtg_core_monitor.sv
`include "sdtg_defines.vh"

module sdtg_core_monitor (
   input logic        core_clk_in,
   input logic        rst_in,
   input logic        clk_en_in,
   input logic        timing_mode_in,
   input logic [1:0]  sync_mode_in,
   input logic        rgb_offset_select_in,
   input logic        clip_enable_in,
   input logic        stage_bypass_in,
   input logic        fullscale_select_in,
   input logic [9:0]  luma_sync_low_level_code_in,
   input logic [9:0]  video_g_y_in,
   input logic [9:0]  video_b_pb_in,
   input logic [10:0] dac_g_y_out,
   input logic [10:0] dac_b_pb_out,
   input logic        dac_fullscale_out,
   input logic        line_sync_out,
   input logic [9:0]  line_count_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   wire [10:0] off = `SDTG_DC_OFFSET;
   // Codes that the clip stage leaves untouched
   wire        raw_g = stage_bypass_in || !clip_enable_in ||
                       (video_g_y_in >= `SDTG_CODE_LO &&
                        video_g_y_in <= `SDTG_LUMA_HI);
   wire        raw_b = stage_bypass_in || !clip_enable_in ||
                       (video_b_pb_in >= `SDTG_CODE_LO &&
                        video_b_pb_in <= `SDTG_LUMA_HI);

   chk_scale_copy: assert property (
      clk_en_in |=> dac_fullscale_out == $past(fullscale_select_in))
      else $error("full-scale flag not copied");
   chk_freeze_hold: assert property (
      !clk_en_in |=> $stable(dac_g_y_out) && $stable(line_count_out))
      else $error("outputs moved while frozen");
   chk_mon_luma: assert property (
      (clk_en_in && timing_mode_in && raw_g) |=>
      dac_g_y_out == {1'b0, $past(video_g_y_in)} + off)
      else $error("monitor luma not from input bus");
   chk_mon_chroma: assert property (
      (clk_en_in && timing_mode_in && raw_b) |=> dac_b_pb_out ==
      {1'b0, $past(video_b_pb_in)} +
      ($past(rgb_offset_select_in) ? off : 11'h000))
      else $error("monitor chroma offset wrong");
   chk_clip_floor: assert property (
      (clk_en_in && timing_mode_in && clip_enable_in && !stage_bypass_in &&
       video_g_y_in < `SDTG_CODE_LO) |=>
      dac_g_y_out == {1'b0, `SDTG_CODE_LO} + off)
      else $error("low luma code not clipped");
   chk_count_step: assert property (
      (line_count_out != $past(line_count_out) && line_count_out != 10'd1)
      |-> line_count_out == $past(line_count_out) + 10'd1)
      else $error("line count skipped");
   chk_line_wrap: assert property (
      (line_count_out != $past(line_count_out) && line_count_out == 10'd1)
      |-> $past(line_count_out) == 10'd525)
      else $error("frame wrapped at wrong line");
   chk_line_range: assert property (
      line_count_out >= 10'd1 && line_count_out <= 10'd525)
      else $error("line count out of range");
   chk_green_tip: assert property (
      (line_sync_out && $past(clk_en_in) && !$past(timing_mode_in) &&
       $past(sync_mode_in) == `SDTG_SYNC_GREEN) |->
      dac_g_y_out == {1'b0, $past(luma_sync_low_level_code_in)} + off)
      else $error("green sync tip level wrong");

   cover property (timing_mode_in && clk_en_in);
   cover property ($rose(line_sync_out));
   cover property (!clk_en_in ##1 clk_en_in);
endmodule // sdtg_core_monitor

bind sdtg_core sdtg_core_monitor u_mon (.*);

// File: dv/sdtg_core_tb.sv
`include "sdtg_defines.vh"

module sdtg_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int G = 20, TOT = 40, A = 3, C = 2, H = 7;
   localparam int D = 8, D1 = 4, K = 4, K1 = 3;
   localparam logic [10:0] OFF = `SDTG_DC_OFFSET;
   logic        clk = 1'b0, rst = 1'b1, en = 1'b1, tmode = 1'b0;
   logic        fwd = 1'b0, rgb = 1'b0, clip = 1'b1, byp = 1'b0;
   logic        fs = 1'b0, rgbq, fsq, lso_q = 1'b0, sd_on = 1'b1;
   logic        bypq, clipq;
   logic [1:0]  smode = 2'h1;
   logic [10:0] wa = 11'(A), wc = 11'(C), wh = 11'(H), wg = 11'(G);
   logic [10:0] wd = 11'(D), wd1 = 11'(D1), wk = 11'(K), wk1 = 11'(K1);
   logic [11:0] wt = 12'(TOT);
   logic [9:0]  yb = 10'h070, yl = 10'h040, yh = 10'h0a0;
   logic [9:0]  cb = 10'h070, cl = 10'h040, chh = 10'h0a0;
   logic [9:0]  vg, vb, vr, vq, bq, lc;
   logic [10:0] dg, db, dr, ex;
   logic        fso, lso, vso, fld;
   logic [3:0]  lt;
   int          err_count = 0, num_checks = 0;
   int          ln = 0, cyc = 0, t_rise = 0, vcnt = 0, wcnt = 0;
   int          lines = 0, e_sm = 1, e_fwd = 0, e_rgb = 0, i;

   sdtg_video_src src (.core_clk_in(clk), .wide_in(!sd_on), .g_y_out(vg),
      .b_pb_out(vb),
      .r_pr_out(vr));
   sdtg_core dut (
      .core_clk_in(clk), .rst_in(rst), .clk_en_in(en),
      .timing_mode_in(tmode), .sync_mode_in(smode),
      .video_forward_enable_in(fwd), .rgb_offset_select_in(rgb),
      .clip_enable_in(clip), .stage_bypass_in(byp),
      .fullscale_select_in(fs), .normal_sync_width_in(wa),
      .equalize_pulse_width_in(wc), .broad_pulse_width_in(wh),
      .half_line_length_in(wg), .picture_start_offset_in(wd),
      .second_half_picture_start_in(wd1), .picture_end_offset_in(wk),
      .first_half_picture_end_in(wk1), .pixels_per_line_in(wt),
      .luma_blank_level_code_in(yb), .luma_sync_low_level_code_in(yl),
      .luma_sync_high_level_code_in(yh), .chroma_blank_level_code_in(cb),
      .chroma_sync_low_level_code_in(cl),
      .chroma_sync_high_level_code_in(chh),
      .video_g_y_in(vg), .video_b_pb_in(vb), .video_r_pr_in(vr),
      .dac_g_y_out(dg), .dac_b_pb_out(db), .dac_r_pr_out(dr),
      .dac_fullscale_out(fso), .line_sync_out(lso),
      .frame_sync_out(vso), .field_out(fld), .line_count_out(lc));

   function automatic logic [3:0] ltype(int n);
      if (n < 4 || (n >= 7 && n < 10) || n == 264 || n == 265 ||
          n == 270 || n == 271) return `SDTG_LT_DOUBLE_EQUALIZE;
      if (n < 7 || n == 267 || n == 268) return `SDTG_LT_DOUBLE_BROAD;
      if (n < 20 || (n > 272 && n < 282))
         return `SDTG_LT_FULL_NORMAL_SYNC;
      case (n)
         263: return `SDTG_LT_PICTURE_EQUALIZE;
         266: return `SDTG_LT_EQUALIZE_BROAD;
         269: return `SDTG_LT_BROAD_EQUALIZE;
         272: return `SDTG_LT_FULL_EQUALIZE;
         282: return `SDTG_LT_SYNC_PICTURE;
         default: return `SDTG_LT_PICTURE;
      endcase
   endfunction

   function automatic int llen(logic [3:0] t);
      if (t == `SDTG_LT_PICTURE_EQUALIZE) return 2 * G + K - K1;
      if (t == `SDTG_LT_SYNC_PICTURE) return 2 * G - K + K1 + 1;
      return TOT;
   endfunction

   function automatic int vexp(logic [3:0] t, int f);
      case (t)
         `SDTG_LT_PICTURE: return TOT - D - K;
         `SDTG_LT_PICTURE_EQUALIZE: return G - D - K1;
         `SDTG_LT_SYNC_PICTURE: return G - D1 - K;
         `SDTG_LT_FULL_NORMAL_SYNC: return f ? 2 * G - A - 4 : 0;
         default: return 0;
      endcase
   endfunction

   function automatic logic brd(logic [3:0] t);
      return t == `SDTG_LT_DOUBLE_BROAD || t == `SDTG_LT_EQUALIZE_BROAD ||
             t == `SDTG_LT_BROAD_EQUALIZE;
   endfunction

   // Width of the first sync tip of a line
   function automatic int swid(logic [3:0] t);
      if (t == `SDTG_LT_DOUBLE_BROAD || t == `SDTG_LT_BROAD_EQUALIZE)
         return H;
      if (t == `SDTG_LT_DOUBLE_EQUALIZE || t == `SDTG_LT_EQUALIZE_BROAD ||
          t == `SDTG_LT_FULL_EQUALIZE)
         return C;
      return A;
   endfunction

   // Monitor-mode converter code: clip stage, then offset
   function automatic logic [10:0] mexp(logic [9:0] v, hi, logic c, b, o);
      logic [9:0] x;
      x = v;
      if (!b && c && v < `SDTG_CODE_LO)
         x = `SDTG_CODE_LO;
      if (!b && c && v > hi)
         x = hi;
      return {1'b0, x} + (o ? OFF : 11'h0);
   endfunction

   task automatic cmp_code(input logic [10:0] got, exp, input string m);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic cmp_int(input int got, exp, input string m);
      num_checks++;
      if (got != exp) begin
         err_count++;
         $display("BAD %0t %s got %0d exp %0d", $time, m, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      forever #2 clk = ~clk;
   end

   always @(posedge clk)
      if (en) begin
         vq <= vg;
         bq <= vb;
         rgbq <= rgb;
         fsq <= fs;
         bypq <= byp;
         clipq <= clip;
      end

   // Line model: one line runs from one sync rise to the next
   always @(negedge clk) begin
      cyc++;
      if (lso) wcnt++;
      if (sd_on && dg === {1'b0, vq} + OFF) vcnt++;
      if (sd_on && !lso && lso_q)
         cmp_int(wcnt, swid(lt), "sync width");
      if (sd_on && lso && !lso_q) begin
         lt = ltype(ln);
         if (lines > 0) begin
            cmp_int(cyc - t_rise, llen(lt), "line length");
            cmp_int(vcnt, vexp(lt, e_fwd), "video span");
         end
         ln = ln % 525 + 1;
         lt = ltype(ln);
         cmp_code(11'(lc), 11'(ln), "line number");
         cmp_code(11'(fld), 11'(ln > 263), "field");
         cmp_code(11'(vso), 11'(brd(lt)), "frame sync");
         ex = 11'((e_sm == 1 || e_sm == 2) ? yl : yb) + OFF;
         cmp_code(dg, ex, "luma tip");
         ex = 11'(e_sm == 2 ? cl : cb) + (e_rgb != 0 ? OFF : 11'h0);
         cmp_code(dr, ex, "chroma tip");
         smode = 2'($urandom);
         fwd = 1'($urandom);
         rgb = 1'($urandom);
         fs = 1'($urandom);
         e_sm = smode;
         e_fwd = fwd;
         e_rgb = rgb;
         t_rise = cyc;
         vcnt = 0;
         wcnt = 1;
         lines++;
      end
      lso_q = lso;
   end

   initial begin
      void'($urandom(32'h906a82bc));
      yl = 10'h040 + 10'($urandom % 32);
      yb = 10'h070 + 10'($urandom % 32);
      cl = 10'h040 + 10'($urandom % 32);
      cb = 10'h070 + 10'($urandom % 32);
      repeat (3) @(negedge clk);
      rst = 1'b0;
      for (i = 0; i < 30000 && lines < 530; i++) @(negedge clk);
      cmp_int(int'(lines >= 530), 1, "frame not completed");
      $display("test sd_frame done");
      sd_on = 1'b0;
      tmode = 1'b1;
      repeat (2) @(negedge clk);
      for (i = 0; i < 300; i++) begin
         @(negedge clk);
         ex = mexp(vq, `SDTG_LUMA_HI, clipq, bypq, 1'b1);
         cmp_code(dg, ex, "monitor luma");
         ex = mexp(bq, rgbq ? `SDTG_LUMA_HI : `SDTG_CHROMA_HI, clipq, bypq,
                   rgbq);
         cmp_code(db, ex, "monitor chroma");
         cmp_code(11'(fso), 11'(fsq), "full scale");
         rgb = 1'($urandom);
         fs = 1'($urandom);
         byp = 1'($urandom);
         clip = 1'($urandom);
         en = (i % 50) > 3;
      end
      $display("test monitor done");
      rst = 1'b1;
      @(negedge clk);
      cmp_code(11'(lc), 11'h001, "reset line");
      cmp_code(dg, 11'h000, "reset luma");
      rst = 1'b0;
      $display("test reset done");
      final_report();
   end

   initial begin
      #160us;
      err_count++;
      $display("BAD %0t watchdog expired", $time);
      final_report();
   end
endmodule // sdtg_core_tb
